// file: hdl/pebw_host.sv
// Host-side sequencer that reads, writes and erases a byte-wide parallel memory over its pins.
// Assumes an external pull-up on ready/busy and a level translator behind memHvErase.
`timescale 1ns/1ns
`include "pebw_consts.svh"
module pebw_host
  import pebw_pkg::*;
#(
  parameter int ADDR_W     = `PEBW_ADDR_W,
  parameter int DATA_W     = `PEBW_DATA_W,
  parameter int WC_MAX_CYC = `PEBW_MS_DN(`PEBW_T_WC_MAX_MS),
  parameter int ER_CYC     = `PEBW_MS_DN(`PEBW_T_ER_MS),
  parameter int TIMER_W    = 17
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              clkEn,
  // User command port
  input  wire logic              cmdValid,
  input  wire pebw_cmd_e         cmdKind,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  output logic                   cmdReady,
  // User answer port
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  output logic                   rspTimeout,
  output logic                   rspRefused,
  // Supply supervisor level, high when above the lockout level
  input  wire logic              supplyOkPin,
  // Memory pins
  output logic                   memCeN,
  output logic                   memOeN,
  output logic                   memWeN,
  output logic [ADDR_W-1:0]      memAddr,
  output logic [DATA_W-1:0]      memDataOut,
  output logic                   memDataOe,
  input  wire logic [DATA_W-1:0] memDataIn,
  input  wire logic              memRdyBusyIn,
  output logic                   memHvErase
);

  // Cycle counts derived from the printed times
  localparam int CS_CYC    = `PEBW_NS_UP(`PEBW_T_CS_NS);
  localparam int WP_CYC    = `PEBW_NS_UP(`PEBW_T_WP_NS);
  localparam int AH_CYC    = `PEBW_NS_UP(`PEBW_T_AH_NS);
  localparam int RD_CYC    = `PEBW_NS_UP(`PEBW_T_ACC_NS) + `PEBW_SYNC_LAT;
  localparam int DB_CYC    = `PEBW_NS_UP(`PEBW_T_DB_NS) + `PEBW_SYNC_LAT;
  localparam int DF_CYC    = `PEBW_NS_UP(`PEBW_T_DF_NS);
  localparam int ERSU_CYC  = `PEBW_NS_UP(`PEBW_T_ERSU_NS);
  localparam int ERREC_CYC = `PEBW_US_UP(`PEBW_T_ERREC_US);

  // Refuse a data width without the polled bit and sizes the timers cannot hold
  if (DATA_W <= `PEBW_TOP_BIT) begin : gDataChk
    $error("DATA_W too small for the polled bit");
  end
  if ((WC_MAX_CYC >= (2 ** TIMER_W)) || (ER_CYC >= (2 ** TIMER_W)) || (WC_MAX_CYC < 1) || (ER_CYC < 1)) begin : gTmrChk
    $error("TIMER_W too small for the long counts");
  end

  function automatic logic [TIMER_W-1:0] ld(input int cyc);
    ld = TIMER_W'(cyc - 1);
  endfunction

  pebw_state_e         state_r;
  pebw_state_e         state_nxt;
  logic [TIMER_W-1:0]  timer_r;
  logic [TIMER_W-1:0]  timer_nxt;
  logic [TIMER_W-1:0]  wcTimer_r;
  logic                polling_r;
  logic                refused_r;
  logic                timedOut_r;
  logic                isWrite_r;
  logic [DATA_W-1:0]   wrData_r;
  logic [DATA_W-1:0]   dataSync;
  logic                rdySync;
  logic                supplyOk;
  logic                accept;
  logic                pollDone;

  // Pins from the far side pass the filtered synchroniser
  pebw_pin_sync #(.W(DATA_W + 2)) uSync (
    .clk     (clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .pinIn   ({memDataIn, memRdyBusyIn, supplyOkPin}),
    .syncOut ({dataSync, rdySync, supplyOk})
  );

  assign accept   = cmdValid && cmdReady;
  // Wired ready line floats high only when every memory is done
  assign pollDone = (dataSync[`PEBW_TOP_BIT] == wrData_r[`PEBW_TOP_BIT]) && rdySync;

  // Next state and cycle timer
  always_comb begin
    state_nxt = state_r;
    timer_nxt = (timer_r != '0) ? timer_r - TIMER_W'(1) : timer_r;
    case (state_r)
      PEBW_ST_IDLE: begin
        if (accept) begin
          case (cmdKind)
            PEBW_CMD_READ: begin
              state_nxt = PEBW_ST_RD_WAIT;
              timer_nxt = ld(RD_CYC);
            end
            PEBW_CMD_WRITE: begin
              // Low supply refuses the write before any strobe moves
              state_nxt = supplyOk ? PEBW_ST_WR_SETUP : PEBW_ST_RESP;
              timer_nxt = ld(CS_CYC);
            end
            PEBW_CMD_ERASE: begin
              // Lockout does not gate the high-voltage erase
              state_nxt = PEBW_ST_ER_SETUP;
              timer_nxt = ld(ERSU_CYC);
            end
            default: state_nxt = PEBW_ST_RESP;
          endcase
        end
      end
      PEBW_ST_RD_WAIT: begin
        if (timer_r == '0) begin
          if (!polling_r || pollDone || (wcTimer_r == '0)) begin
            state_nxt = PEBW_ST_RESP;
          end else begin
            state_nxt = PEBW_ST_GAP;
            timer_nxt = ld(DF_CYC);
          end
        end
      end
      PEBW_ST_WR_SETUP: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_WR_PULSE;
          timer_nxt = ld(WP_CYC);
        end
      end
      PEBW_ST_WR_PULSE: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_WR_HOLD;
          timer_nxt = ld(AH_CYC);
        end
      end
      PEBW_ST_WR_HOLD: begin
        if (timer_r == '0) begin
          // Memory holds its own copy now, so the bus is released
          state_nxt = PEBW_ST_GAP;
          timer_nxt = ld(DB_CYC);
        end
      end
      PEBW_ST_GAP: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_RD_WAIT;
          timer_nxt = ld(RD_CYC);
        end
      end
      PEBW_ST_ER_SETUP: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_ER_PULSE;
          timer_nxt = ld(ER_CYC);
        end
      end
      PEBW_ST_ER_PULSE: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_ER_REC;
          timer_nxt = ld(ERREC_CYC);
        end
      end
      PEBW_ST_ER_REC: begin
        if (timer_r == '0) begin
          state_nxt = PEBW_ST_RESP;
        end
      end
      PEBW_ST_RESP: state_nxt = PEBW_ST_IDLE;
      default:      state_nxt = PEBW_ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= PEBW_ST_IDLE;
      timer_r <= '0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // Write-cycle deadline; no new access until the memory is done or the bound has passed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wcTimer_r <= '0;
      polling_r <= 1'b0;
    end else if (clkEn) begin
      if ((state_r == PEBW_ST_WR_HOLD) && (state_nxt == PEBW_ST_GAP)) begin
        wcTimer_r <= ld(WC_MAX_CYC);
        polling_r <= 1'b1;
      end else begin
        if (wcTimer_r != '0) begin
          wcTimer_r <= wcTimer_r - TIMER_W'(1);
        end
        if (state_r == PEBW_ST_RESP) begin
          polling_r <= 1'b0;
        end
      end
    end
  end

  // Command capture; stays fixed for the whole cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memAddr   <= '0;
      wrData_r  <= '0;
      isWrite_r <= 1'b0;
    end else if (clkEn && accept) begin
      memAddr   <= cmdAddr;
      wrData_r  <= cmdData;
      isWrite_r <= (cmdKind == PEBW_CMD_WRITE);
    end
  end

  // Pin drive follows the next state so each pin comes straight from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memCeN     <= 1'b1;
      memOeN     <= 1'b1;
      memWeN     <= 1'b1;
      memDataOe  <= 1'b0;
      memDataOut <= '0;
      memHvErase <= 1'b0;
    end else if (clkEn) begin
      // New byte goes out with the accept, so no stale byte is driven during setup
      memDataOut <= accept ? cmdData : wrData_r;
      // Select low only while an access runs; high means standby with data floating
      memCeN     <= !((state_nxt == PEBW_ST_RD_WAIT) || (state_nxt == PEBW_ST_WR_SETUP) ||
                      (state_nxt == PEBW_ST_WR_PULSE) || (state_nxt == PEBW_ST_WR_HOLD) ||
                      (state_nxt == PEBW_ST_ER_SETUP) || (state_nxt == PEBW_ST_ER_PULSE) ||
                      (state_nxt == PEBW_ST_ER_REC));
      memOeN     <= (state_nxt != PEBW_ST_RD_WAIT);
      // Strobe drops only with select low and a healthy supply; otherwise held high
      memWeN     <= !((state_nxt == PEBW_ST_WR_PULSE) && supplyOk);
      // Host drives data only while output enable is high, avoiding contention
      memDataOe  <= (state_nxt == PEBW_ST_WR_SETUP) || (state_nxt == PEBW_ST_WR_PULSE) ||
                    (state_nxt == PEBW_ST_WR_HOLD);
      memHvErase <= (state_nxt == PEBW_ST_ER_PULSE);
    end
  end

  // Outcome flags of the running command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refused_r  <= 1'b0;
      timedOut_r <= 1'b0;
    end else if (clkEn) begin
      if (accept) begin
        refused_r  <= (cmdKind == PEBW_CMD_WRITE) && !supplyOk;
        timedOut_r <= 1'b0;
      end else if ((state_r == PEBW_ST_RD_WAIT) && (timer_r == '0) && polling_r && !pollDone &&
                   (wcTimer_r == '0)) begin
        timedOut_r <= 1'b1;
      end
    end
  end

  // User answer; active-high ready shows only in idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmdReady   <= 1'b0;
      rspValid   <= 1'b0;
      rspData    <= '0;
      rspTimeout <= 1'b0;
      rspRefused <= 1'b0;
    end else if (clkEn) begin
      cmdReady <= (state_nxt == PEBW_ST_IDLE) && !accept;
      rspValid <= (state_r == PEBW_ST_RESP);
      if (state_r == PEBW_ST_RESP) begin
        rspData    <= isWrite_r ? wrData_r : dataSync;
        rspTimeout <= timedOut_r;
        rspRefused <= refused_r;
      end
    end
  end

endmodule

// file: hdl/pebw_consts.svh
// Constants for the host-side controller of a byte-wide parallel nonvolatile memory.
// Assumes a 10 MHz clock. Included by its bare name; holds definitions only.
`ifndef PEBW_CONSTS_SVH
`define PEBW_CONSTS_SVH

// Bus geometry
`define PEBW_ADDR_W        11
`define PEBW_DATA_W        8
`define PEBW_TOP_BIT       7

// Clock rate
`define PEBW_CLK_MHZ       10

// Pin timing, printed units
`define PEBW_T_CS_NS       20
`define PEBW_T_WP_NS       150
`define PEBW_T_AH_NS       50
`define PEBW_T_ACC_NS      200
`define PEBW_T_DB_NS       120
`define PEBW_T_DF_NS       80
`define PEBW_T_ERSU_NS     10
`define PEBW_T_ERREC_US    1
`define PEBW_T_WC_MAX_MS   10
`define PEBW_T_ER_MS       10

// Extra cycles the three-stage pin synchroniser adds before a change shows
`define PEBW_SYNC_LAT      4

// Least times round up, longest times round down
`define PEBW_NS_UP(ns)     (((ns) * `PEBW_CLK_MHZ + 999) / 1000)
`define PEBW_US_UP(us)     ((us) * `PEBW_CLK_MHZ)
`define PEBW_MS_DN(ms)     ((ms) * `PEBW_CLK_MHZ * 1000)

// Reset level of the synchronised inputs
`define PEBW_RST_LOW       1'b0

`endif

// file: hdl/pebw_pkg.sv
// Types shared by the parallel memory host controller.
// Assumes nothing beyond the constants header.
package pebw_pkg;

  // Command kinds offered on the user port
  typedef enum logic [1:0] {
    PEBW_CMD_READ,
    PEBW_CMD_WRITE,
    PEBW_CMD_ERASE
  } pebw_cmd_e;

  // Sequencer states
  typedef enum logic [3:0] {
    PEBW_ST_IDLE,
    PEBW_ST_RD_WAIT,
    PEBW_ST_WR_SETUP,
    PEBW_ST_WR_PULSE,
    PEBW_ST_WR_HOLD,
    PEBW_ST_GAP,
    PEBW_ST_ER_SETUP,
    PEBW_ST_ER_PULSE,
    PEBW_ST_ER_REC,
    PEBW_ST_RESP
  } pebw_state_e;

endpackage

// file: hdl/pebw_pin_sync.sv
// Three-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes clkEn freezes it with the rest of the controller.
`timescale 1ns/1ns
module pebw_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  // Pin side and clean side
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  // Shift chain; stage one is read only by stage two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else if (clkEn) begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Each bit changes only once its stages two and three agree, filtering one-cycle glitches
  // Agreement is per bit, so a toggling data pin never holds back ready or supply
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncOut <= '0;
    end else if (clkEn) begin
      syncOut <= (stage3_r & ~(stage2_r ^ stage3_r)) | (syncOut & (stage2_r ^ stage3_r));
    end
  end

endmodule

// file: verif/pebw_host_monitor.sv
// Pin-side checker for pebw_host.
// Assumes it is bound to every pebw_host instance.
`timescale 1ns/1ns
module pebw_host_monitor #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
) (
  // Clock, reset, user port
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              cmdValid,
  input wire logic              cmdReady,
  input wire logic              rspValid,
  // Memory side
  input wire logic              supplyOkPin,
  input wire logic              memCeN,
  input wire logic              memOeN,
  input wire logic              memWeN,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [DATA_W-1:0] memDataOut,
  input wire logic              memDataOe,
  input wire logic              memRdyBusyIn,
  input wire logic              memHvErase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Strobe qualification; supply lag covers the synchroniser
  a_we_gated: assert property (!memWeN |-> !memCeN && memOeN)
    else $error("write strobe not qualified");
  a_we_width: assert property ($fell(memWeN) |=> !memWeN ##1 memWeN)
    else $error("write pulse width wrong");
  a_low_supply: assert property (!supplyOkPin [*8] |-> memWeN)
    else $error("write strobe with supply low");
  a_busy_wait: assert property (!memRdyBusyIn |-> memWeN)
    else $error("write strobe while busy");
  // Bus ownership and latching
  a_read_owner: assert property (!memOeN |-> !memCeN && !memDataOe)
    else $error("read without select or with bus driven");
  a_wr_held: assert property (!memWeN |-> memDataOe && $stable(memAddr) && $stable(memDataOut))
    else $error("address or data moved in pulse");
  a_hv_select: assert property ($rose(memHvErase) |-> !$past(memCeN) && !memCeN)
    else $error("erase voltage without select");
  // User handshake
  a_ready_drop: assert property (cmdValid && cmdReady |=> !cmdReady && !rspValid)
    else $error("ready stayed up after accept");
  a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
endmodule

bind pebw_host pebw_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon_u (
  .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .rspValid(rspValid), .supplyOkPin(supplyOkPin), .memCeN(memCeN), .memOeN(memOeN),
  .memWeN(memWeN), .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe),
  .memRdyBusyIn(memRdyBusyIn), .memHvErase(memHvErase));

// file: verif/pebw_mem_model.sv
// Behavioural byte-wide memory on the far side of the host.
// Assumes the bench pulls the ready line up.
`timescale 1ns/1ns
module pebw_mem_model #(
  parameter int PHASE_CYC = 20,
  parameter int ER_MIN    = 40
) (
  // Clock and bench controls
  input  wire logic        clk,
  input  wire logic        supplyOk,
  input  wire logic        stuckBusy,
  // Memory pins
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        hvErase,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  dIn,
  output logic      [7:0]  dOut,
  output logic             busyPull
);
  logic [7:0]  memArr [2048];
  logic [10:0] latAddr = '0;
  logic [7:0]  latData = '0;
  logic        armR    = 1'b0;
  logic        flipR   = 1'b0;
  int          busyCnt = 0;
  int          hvCnt   = 0;

  initial foreach (memArr[i]) memArr[i] = 8'h00;

  // Only a low strobe seen at an edge arms a write, so glitches are lost
  always @(posedge clk) begin
    flipR <= !flipR;
    armR <= !weN && !ceN && oeN && supplyOk;
    if (weN && armR && busyCnt == 0) begin
      latAddr <= addr;
      latData <= dIn;
      busyCnt <= 2 * PHASE_CYC;
    end else if (busyCnt > 0 && !stuckBusy) begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == PHASE_CYC + 1) memArr[latAddr] <= 8'hFF;
      if (busyCnt == 1) memArr[latAddr] <= latData;
    end
    hvCnt <= (hvErase && !ceN) ? hvCnt + 1 : 0;
    if (!hvErase && hvCnt >= ER_MIN) foreach (memArr[i]) memArr[i] <= 8'hFF;
  end

  // A released bus shows a changing pattern, never the last byte
  always_comb begin
    dOut = 8'hA5 ^ {8{flipR}};
    if (!ceN && !oeN) begin
      dOut = memArr[addr];
      if (busyCnt > 0 && addr == latAddr) dOut[7] = ~latData[7];
    end
  end
  assign busyPull = (busyCnt > 0);
endmodule

// file: verif/parallel_eeprom_byte_write_ctrl_tb.sv
// Self-checking bench: pebw_host against a behavioural memory.
// Assumes the model and the bound checker are compiled first.
`timescale 1ns/1ns
module parallel_eeprom_byte_write_ctrl_tb;
  import pebw_pkg::*;

  localparam int WC_CYC = 200;
  localparam int ER_CYC = 50;
  localparam int PHASE  = 20;

  logic        clk, resetn, clkEn, cmdValid, cmdReady, rspValid;
  logic        rspTimeout, rspRefused, supplyOk, stuckBusy;
  logic        memCeN, memOeN, memWeN, memDataOe, memHvErase, busyPull;
  logic [10:0] cmdAddr, memAddr;
  logic [7:0]  cmdData, rspData, memDataOut, memDataIn;
  pebw_cmd_e   cmdKind;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          weFalls     = 0;
  int          took;

  // Scaled bounds keep the run short; ready line is pulled up
  pebw_host #(.WC_MAX_CYC(WC_CYC), .ER_CYC(ER_CYC)) dut_u (
    .clk(clk), .resetn(resetn), .clkEn(clkEn), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData), .rspTimeout(rspTimeout), .rspRefused(rspRefused),
    .supplyOkPin(supplyOk), .memCeN(memCeN), .memOeN(memOeN), .memWeN(memWeN),
    .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe),
    .memDataIn(memDataIn), .memRdyBusyIn(!busyPull), .memHvErase(memHvErase));

  // Undriven host data reads as the inverse, never a stale match
  pebw_mem_model #(.PHASE_CYC(PHASE), .ER_MIN(40)) mem_u (
    .clk(clk), .supplyOk(supplyOk), .stuckBusy(stuckBusy), .ceN(memCeN), .oeN(memOeN),
    .weN(memWeN), .hvErase(memHvErase), .addr(memAddr),
    .dIn(memDataOe ? memDataOut : ~memDataOut), .dOut(memDataIn), .busyPull(busyPull));

  // Clock and strobe counter
  always #50 clk = ~clk;
  always @(negedge memWeN) weFalls++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hold the request until taken, then wait for the answer pulse
  task automatic run_cmd(input pebw_cmd_e k, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    cmdValid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 3000);
    cmdValid <= 1'b0;
    took = n;
    while (rspValid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    took = n - took;
    if (n >= 3000) begin
      miscompares++;
      complete_run();
    end
  endtask

  // Writes at both address ends, polled to completion, read back
  task automatic sc_write_read;
    logic [10:0] adr [2] = '{11'h000, 11'h7FF};
    logic [7:0]  dat [2] = '{8'h5A, 8'hC3};
    for (int i = 0; i < 2; i++) begin
      run_cmd(PEBW_CMD_WRITE, adr[i], dat[i]);
      check({6'h00, rspTimeout, rspRefused}, 8'h00);
      check(8'(took >= 2 * PHASE), 8'h01);
      run_cmd(PEBW_CMD_READ, adr[i], 8'h00);
      check(rspData, dat[i]);
    end
  endtask

  // Low supply: no strobe moves and the byte stays untouched
  task automatic sc_refused;
    int w;
    supplyOk <= 1'b0;
    repeat (8) @(posedge clk);
    w = weFalls;
    run_cmd(PEBW_CMD_WRITE, 11'h010, 8'h77);
    check({7'h00, rspRefused}, 8'h01);
    check(8'(weFalls - w), 8'h00);
    supplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    run_cmd(PEBW_CMD_READ, 11'h010, 8'h00);
    check(rspData, 8'h00);
  endtask

  // Memory that never finishes: host gives up, late byte lands intact
  task automatic sc_timeout;
    stuckBusy <= 1'b1;
    run_cmd(PEBW_CMD_WRITE, 11'h020, 8'h11);
    check({7'h00, rspTimeout}, 8'h01);
    check(8'(took >= WC_CYC), 8'h01);
    stuckBusy <= 1'b0;
    repeat (3 * PHASE) @(posedge clk);
    run_cmd(PEBW_CMD_READ, 11'h020, 8'h00);
    check(rspData, 8'h11);
  endtask

  // Low enable in mid-read holds every stage; the read still returns the byte
  task automatic sc_freeze;
    fork
      run_cmd(PEBW_CMD_READ, 11'h000, 8'h00);
      begin
        repeat (3) @(posedge clk);
        clkEn <= 1'b0;
        repeat (20) @(posedge clk);
        clkEn <= 1'b1;
      end
    join
    check(rspData, 8'h5A);
    check(8'(took >= 27), 8'h01);
  endtask

  // Whole-array erase with supply low still sets every bit
  task automatic sc_erase;
    supplyOk <= 1'b0;
    repeat (8) @(posedge clk);
    run_cmd(PEBW_CMD_ERASE, 11'h000, 8'h00);
    supplyOk <= 1'b1;
    repeat (8) @(posedge clk);
    run_cmd(PEBW_CMD_READ, 11'h7FF, 8'h00);
    check(rspData, 8'hFF);
    run_cmd(PEBW_CMD_READ, 11'h020, 8'h00);
    check(rspData, 8'hFF);
  endtask

  // Main sequence
  initial begin
    {clk, clkEn, cmdValid, stuckBusy} = 4'b0100;
    resetn = 1'b0;
    supplyOk = 1'b1;
    cmdKind = PEBW_CMD_READ;
    {cmdAddr, cmdData} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    sc_write_read();
    sc_refused();
    sc_timeout();
    sc_freeze();
    sc_erase();
    complete_run();
  end
endmodule
